// File: verilog/tsa_trace_annotator.v
// Functional notes
// - The trigger state gets line zero; earlier lines negative, later positive.
// - Instruction request type high tags an instruction ROM access.
// - Option code 100 tags ROM read as data in data and status modes.
// - Pipelined instruction access low tags a pipelined fetch, status mode only.
// - Trap request zero low tags trap zero in D/I and status modes.
// - Trap request one low tags trap one in D/I and status modes.
// - Privilege high tags supervisor, low tags user; option 000 tags word access in D/I and status modes.
// - I/D and D/I modes tag from status lines; status mode adds status code lines and drops the request pair.
// - Split setting captures data/instruction before trigger, status after.
// - Switching selection picks the signal; cross trigger one causes the switch.
// - When enabled, the analyzer drives cross trigger one on finding the trigger.
// - The trigger is judged in the mode in force before the trigger.
// - A write to the general configuration breaks execution into the monitor.
// - Status code maps to halt, load test, iret, interrupt, non-sequential, executing.
// - Status capture takes effect several clock cycles after the switch.
`timescale 1ns/100ps
`include "tsa_defs.vh"
module tsa_trace_annotator #(
   parameter ADDR_W    = 32,
   parameter DATA_W    = 32,
   parameter LINE_W    = 16
) (
   input  wire                      clk,
   input  wire                      nrst,
   input  wire                      capture_valid,
   input  wire [ADDR_W-1:0]         bus_address,
   input  wire [DATA_W-1:0]         bus_data,
   input  wire                      trigger_match,
   input  wire                      privilege_level_line,
   input  wire                      instr_request_type,
   input  wire [2:0]                access_option_code,
   input  wire                      pipelined_instr_access_n,
   input  wire                      trap_request_zero_n,
   input  wire                      trap_request_one_n,
   input  wire                      data_request_n,
   input  wire                      instr_request_n,
   input  wire [2:0]                processor_status_code,
   input  wire                      cross_trigger_line_one_in,
   input  wire                      config_write,
   input  wire [1:0]                config_mode,
   input  wire [1:0]                config_switch_select,
   input  wire                      config_drive_cross_one,
   input  wire                      trace_restart,
   output reg                       state_valid,
   output reg  [ADDR_W-1:0]         state_address,
   output reg  [DATA_W-1:0]         state_data,
   output reg  [`TSA_TAG_WIDTH-1:0] state_tags,
   output reg                       state_tags_cut,
   output reg  [LINE_W-1:0]         state_line,
   output reg  [1:0]                state_mode,
   output reg                       trigger_found,
   output reg                       cross_trigger_line_one,
   output reg                       monitor_break_request,
   output reg  [1:0]                active_mode,
   output reg                       int_out
);
   reg  [ADDR_W-1:0]         s1_addr;
   reg  [ADDR_W-1:0]         s2_addr;
   reg  [DATA_W-1:0]         s1_data;
   reg  [DATA_W-1:0]         s2_data;
   reg  [15:0]               s1_stat;
   reg  [15:0]               s2_stat;
   reg                       s1_cross;
   reg                       s2_cross;
   reg  [1:0]                split_setting;
   reg  [1:0]                switch_select;
   reg                       drive_cross;
   reg                       switch_pending;
   reg  [3:0]                latency_count;
   reg  [LINE_W-1:0]         pre_count;
   reg  [LINE_W-1:0]         post_count;
   reg  [LINE_W-1:0]         next_line;
   wire [`TSA_TAG_WIDTH-1:0] tags;
   wire                      trig_now;
   wire                      switch_cause;

   function [4:0] tsa_count_ones;
      input [`TSA_TAG_WIDTH-1:0] v;
      integer i;
      begin
         tsa_count_ones = 5'h00;
         for (i = 0; i < `TSA_TAG_WIDTH; i = i + 1) begin
            tsa_count_ones = tsa_count_ones + {4'h0, v[i]};
         end
      end
   endfunction

   // Pins come from the emulated processor and pass two stages; address, data and
   // status lines move through the same stages so one state stays coherent.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_addr  <= {ADDR_W{1'b0}};
         s2_addr  <= {ADDR_W{1'b0}};
         s1_data  <= {DATA_W{1'b0}};
         s2_data  <= {DATA_W{1'b0}};
         s1_stat  <= 16'h0000;
         s2_stat  <= 16'h0000;
         s1_cross <= 1'b0;
         s2_cross <= 1'b0;
      end else begin
         s1_addr  <= bus_address;
         s2_addr  <= s1_addr;
         s1_data  <= bus_data;
         s2_data  <= s1_data;
         s1_stat  <= {capture_valid, trigger_match, privilege_level_line,
                      instr_request_type, access_option_code, pipelined_instr_access_n,
                      trap_request_zero_n, trap_request_one_n, data_request_n,
                      instr_request_n, processor_status_code, 1'b0};
         s2_stat  <= s1_stat;
         s1_cross <= cross_trigger_line_one_in;
         s2_cross <= s1_cross;
      end
   end

   tsa_tag_decode u_decode (
      .mode                     (active_mode),
      .privilege_level_line     (s2_stat[13]),
      .instr_request_type       (s2_stat[12]),
      .access_option_code       (s2_stat[11:9]),
      .pipelined_instr_access_n (s2_stat[8]),
      .trap_request_zero_n      (s2_stat[7]),
      .trap_request_one_n       (s2_stat[6]),
      .data_request_n           (s2_stat[5]),
      .instr_request_n          (s2_stat[4]),
      .processor_status_code    (s2_stat[3:1]),
      .tags                     (tags)
   );

   // The trigger comparator sees the mode in force before any switch.
   assign trig_now = s2_stat[15] && s2_stat[14] && !trigger_found;
   // An externally driven line also counts, so another analyzer may cause the switch.
   assign switch_cause = (switch_select == `TSA_SW_CROSS1) &&
                         (cross_trigger_line_one || s2_cross);

   always @* begin
      if (trig_now) begin
         next_line = {LINE_W{1'b0}};
      end else if (trigger_found) begin
         next_line = post_count + {{(LINE_W-1){1'b0}}, 1'b1};
      end else begin
         next_line = ~pre_count;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         split_setting         <= `TSA_MODE_RESET;
         switch_select         <= `TSA_SW_RESET;
         drive_cross           <= 1'b0;
         active_mode           <= `TSA_MODE_RESET;
         monitor_break_request <= 1'b0;
      end else begin
         monitor_break_request <= config_write;
         if (config_write) begin
            split_setting <= config_mode;
            switch_select <= config_switch_select;
            drive_cross   <= config_drive_cross_one;
            active_mode   <= (config_mode == `TSA_MODE_SPLIT) ? `TSA_MODE_DI : config_mode;
         end else if (trace_restart) begin
            active_mode <= (split_setting == `TSA_MODE_SPLIT) ? `TSA_MODE_DI : split_setting;
         end else if (switch_pending && latency_count == 4'h1) begin
            active_mode <= `TSA_MODE_STAT;
         end
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         trigger_found          <= 1'b0;
         cross_trigger_line_one <= 1'b0;
         switch_pending         <= 1'b0;
         latency_count          <= 4'h0;
         pre_count              <= {LINE_W{1'b0}};
         post_count             <= {LINE_W{1'b0}};
      end else if (trace_restart || config_write) begin
         trigger_found          <= 1'b0;
         cross_trigger_line_one <= 1'b0;
         switch_pending         <= 1'b0;
         latency_count          <= 4'h0;
         pre_count              <= {LINE_W{1'b0}};
         post_count             <= {LINE_W{1'b0}};
      end else begin
         if (trig_now) begin
            trigger_found <= 1'b1;
            cross_trigger_line_one <= drive_cross;
         end
         if (split_setting == `TSA_MODE_SPLIT && switch_cause && !switch_pending &&
             active_mode != `TSA_MODE_STAT) begin
            switch_pending <= 1'b1;
            latency_count  <= `TSA_SWITCH_LATENCY;
         end else if (switch_pending && latency_count != 4'h0) begin
            latency_count <= latency_count - 4'h1;
            if (latency_count == 4'h1) begin
               switch_pending <= 1'b0;
            end
         end
         if (s2_stat[15]) begin
            if (trigger_found) begin
               post_count <= next_line;
            end else if (!trig_now) begin
               pre_count <= pre_count + {{(LINE_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // Pre-trigger lines are numbered from the oldest downwards, so the display
   // must renumber them once the trigger lands; stored line is the inverted running count.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_valid    <= 1'b0;
         state_address  <= {ADDR_W{1'b0}};
         state_data     <= {DATA_W{1'b0}};
         state_tags     <= {`TSA_TAG_WIDTH{1'b0}};
         state_tags_cut <= 1'b0;
         state_line     <= {LINE_W{1'b0}};
         state_mode     <= `TSA_MODE_RESET;
      end else begin
         state_valid <= s2_stat[15];
         if (s2_stat[15]) begin
            state_address  <= s2_addr;
            state_data     <= s2_data;
            state_tags     <= tags;
            state_tags_cut <= (tsa_count_ones(tags) > `TSA_COLUMN_TAGS);
            state_line     <= next_line;
            state_mode     <= active_mode;
         end
      end
   end

   // Trigger and mode switch are the events; a level interrupt follows them.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         int_out <= 1'b0;
      end else if (trace_restart || config_write) begin
         int_out <= 1'b0;
      end else if (trig_now || (switch_pending && latency_count == 4'h1)) begin
         int_out <= 1'b1;
      end
   end
endmodule

// File: verilog/tsa_defs.vh
`ifndef TSA_DEFS_VH
`define TSA_DEFS_VH
// Analysis modes.
`define TSA_MODE_ID        2'h0
`define TSA_MODE_DI        2'h1
`define TSA_MODE_STAT      2'h2
`define TSA_MODE_SPLIT     2'h3
`define TSA_MODE_RESET     2'h1
// Switching signal selection.
`define TSA_SW_NONE        2'h0
`define TSA_SW_CROSS1      2'h1
`define TSA_SW_RESET       2'h0
// Option codes.
`define TSA_OPT_WORD       3'h0
`define TSA_OPT_ROM_DATA   3'h4
// Status codes.
`define TSA_ST_HALT        3'h0
`define TSA_ST_LOAD_TEST   3'h2
`define TSA_ST_IRET        3'h4
`define TSA_ST_TAKE_INT    3'h5
`define TSA_ST_NONSEQ      3'h6
`define TSA_ST_EXEC        3'h7
// Tag vector bit positions.
`define TSA_TAG_SUP        0
`define TSA_TAG_USER       1
`define TSA_TAG_ROM        2
`define TSA_TAG_ROM_DATA   3
`define TSA_TAG_PIPE       4
`define TSA_TAG_TRAP_REQUEST_ZERO_N      5
`define TSA_TAG_TRAP_REQUEST_ONE_N      6
`define TSA_TAG_WORD       7
`define TSA_TAG_BOTH_REQ   8
`define TSA_TAG_HALT       9
`define TSA_TAG_LOAD_TEST  10
`define TSA_TAG_IRET       11
`define TSA_TAG_TAKE_INT   12
`define TSA_TAG_NONSEQ     13
`define TSA_TAG_EXEC       14
`define TSA_TAG_WIDTH      15
// Clock cycles until status capture is in effect after a switch.
`define TSA_SWITCH_LATENCY 4'h3
// Tags that the display column can hold.
`define TSA_COLUMN_TAGS    5'h06
`endif

// File: verilog/tsa_tag_decode.v
`timescale 1ns/100ps
`include "tsa_defs.vh"
module tsa_tag_decode (
   input  wire [1:0]                mode,
   input  wire                      privilege_level_line,
   input  wire                      instr_request_type,
   input  wire [2:0]                access_option_code,
   input  wire                      pipelined_instr_access_n,
   input  wire                      trap_request_zero_n,
   input  wire                      trap_request_one_n,
   input  wire                      data_request_n,
   input  wire                      instr_request_n,
   input  wire [2:0]                processor_status_code,
   output reg  [`TSA_TAG_WIDTH-1:0] tags
);
   reg st;
   reg dm;
   always @* begin
      st = (mode == `TSA_MODE_STAT);
      dm = (mode == `TSA_MODE_DI) || st;
      tags = {`TSA_TAG_WIDTH{1'b0}};
      tags[`TSA_TAG_SUP]       = privilege_level_line;
      tags[`TSA_TAG_USER]      = ~privilege_level_line;
      tags[`TSA_TAG_ROM]       = instr_request_type;
      tags[`TSA_TAG_ROM_DATA]  = dm && (access_option_code == `TSA_OPT_ROM_DATA);
      tags[`TSA_TAG_PIPE]      = st && ~pipelined_instr_access_n;
      tags[`TSA_TAG_TRAP_REQUEST_ZERO_N]     = dm && ~trap_request_zero_n;
      tags[`TSA_TAG_TRAP_REQUEST_ONE_N]     = dm && ~trap_request_one_n;
      tags[`TSA_TAG_WORD]      = dm && (access_option_code == `TSA_OPT_WORD);
      // Status mode leaves the data and instruction request pair out of the tags.
      tags[`TSA_TAG_BOTH_REQ]  = ~st && ~data_request_n && ~instr_request_n;
      tags[`TSA_TAG_HALT]      = st && (processor_status_code == `TSA_ST_HALT);
      tags[`TSA_TAG_LOAD_TEST] = st && (processor_status_code == `TSA_ST_LOAD_TEST);
      tags[`TSA_TAG_IRET]      = st && (processor_status_code == `TSA_ST_IRET);
      tags[`TSA_TAG_TAKE_INT]  = st && (processor_status_code == `TSA_ST_TAKE_INT);
      tags[`TSA_TAG_NONSEQ]    = st && (processor_status_code == `TSA_ST_NONSEQ);
      tags[`TSA_TAG_EXEC]      = st && (processor_status_code == `TSA_ST_EXEC);
   end
endmodule

// File: dv/tsa_cpu_model.sv
`timescale 1ns/100ps
module tsa_cpu_model (
   input  wire        go,
   input  wire        trig,
   input  wire [12:0] pat,
   output wire        capture_valid,
   output wire        trigger_match,
   output wire [31:0] bus_address,
   output wire [31:0] bus_data,
   output wire [12:0] lines
);
   // Between states the lines show the inverse, so a stale sample never passes for a hit.
   assign capture_valid = go;
   assign trigger_match = trig & go;
   assign bus_address   = go ? {19'h0, pat} : ~{19'h0, pat};
   assign bus_data      = ~bus_address;
   assign lines         = go ? pat : ~pat;
endmodule

// File: dv/tsa_trace_monitor.sv
`timescale 1ns/100ps
module tsa_trace_monitor #(
   parameter LINE_W = 16
) (
   input wire              clk,
   input wire              nrst,
   input wire              capture_valid,
   input wire              config_write,
   input wire              trace_restart,
   input wire              state_valid,
   input wire [14:0]       state_tags,
   input wire              state_tags_cut,
   input wire [LINE_W-1:0] state_line,
   input wire [1:0]        state_mode,
   input wire              trigger_found,
   input wire              cross_trigger_line_one,
   input wire              monitor_break_request,
   input wire [1:0]        active_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   brk_after_cfg_a: assert property (config_write |=> monitor_break_request)
      else $error("break request missing after config write");
   brk_cause_a: assert property (monitor_break_request |-> $past(config_write))
      else $error("break request without config write");
   valid_delay_a: assert property (capture_valid |-> ##3 state_valid)
      else $error("captured state not delivered in three cycles");
   valid_cause_a: assert property (state_valid |-> $past(capture_valid, 3))
      else $error("state delivered without capture");
   trig_line_a: assert property (state_valid && $rose(trigger_found) |-> state_line == 0)
      else $error("trigger state not on line zero");
   trig_sticky_a: assert property (trigger_found && !trace_restart && !config_write
      |=> trigger_found)
      else $error("trigger flag dropped without restart");
   cross_cause_a: assert property ($rose(cross_trigger_line_one) |-> trigger_found)
      else $error("cross trigger driven before trigger");
   cut_flag_a: assert property (state_valid
      |-> state_tags_cut == ($countones(state_tags) > 6))
      else $error("cut flag disagrees with tag count");
   priv_tags_a: assert property (state_valid |-> state_tags[0] != state_tags[1])
      else $error("privilege tags not exclusive");
   status_only_a: assert property (state_valid && state_mode != 2'h2
      |-> state_tags[14:9] == 6'h00 && !state_tags[4])
      else $error("status tag outside status mode");
   both_req_a: assert property (state_valid && state_mode == 2'h2 |-> !state_tags[8])
      else $error("both request flag in status mode");
   switch_cause_a: assert property (active_mode == 2'h2 && $past(active_mode) != 2'h2
      && !$past(config_write) |-> trigger_found)
      else $error("mode switched without trigger");
endmodule
bind tsa_trace_annotator tsa_trace_monitor #(.LINE_W(LINE_W)) u_mon (.clk(clk), .nrst(nrst),
   .capture_valid(capture_valid), .config_write(config_write), .trace_restart(trace_restart),
   .state_valid(state_valid), .state_tags(state_tags), .state_tags_cut(state_tags_cut),
   .state_line(state_line), .state_mode(state_mode), .trigger_found(trigger_found),
   .cross_trigger_line_one(cross_trigger_line_one), .active_mode(active_mode),
   .monitor_break_request(monitor_break_request));

// File: dv/tsa_trace_annotator_bench.sv
`timescale 1ns/100ps
module tsa_trace_annotator_bench;
   reg         clk, nrst, go, trig, cfg_wr, restart, cfg_drv, xin;
   reg  [12:0] pat;
   reg  [1:0]  cfg_mode, cfg_sel;
   integer     miscompares, checks, i, j;
   wire        cap_v, t_match, sv, cut, tfound, xline, brk, intr;
   wire [31:0] addr, data, sa, sd;
   wire [12:0] ln;
   wire [14:0] tags;
   wire [15:0] sline;
   wire [1:0]  smode, amode;
   tsa_cpu_model u_cpu (.go(go), .trig(trig), .pat(pat), .capture_valid(cap_v),
      .trigger_match(t_match), .bus_address(addr), .bus_data(data), .lines(ln));
   tsa_trace_annotator u_dut (.clk(clk), .nrst(nrst), .capture_valid(cap_v),
      .bus_address(addr), .bus_data(data), .trigger_match(t_match),
      .privilege_level_line(ln[12]), .instr_request_type(ln[11]), .access_option_code(ln[10:8]),
      .pipelined_instr_access_n(ln[7]), .trap_request_zero_n(ln[6]),
      .trap_request_one_n(ln[5]), .data_request_n(ln[4]), .instr_request_n(ln[3]),
      .processor_status_code(ln[2:0]), .cross_trigger_line_one_in(xin),
      .config_write(cfg_wr), .config_mode(cfg_mode), .config_switch_select(cfg_sel),
      .config_drive_cross_one(cfg_drv), .trace_restart(restart), .state_valid(sv),
      .state_address(sa), .state_data(sd), .state_tags(tags), .state_tags_cut(cut),
      .state_line(sline), .state_mode(smode), .trigger_found(tfound),
      .cross_trigger_line_one(xline), .monitor_break_request(brk), .active_mode(amode),
      .int_out(intr));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task give_verdict;
      begin
         $display("checks %0d miscompares %0d", checks, miscompares);
         if (miscompares == 0 && checks > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input [15:0] exp, input [15:0] got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t expected %h got %h", $time, exp, got);
         end
      end
   endtask
   // Expected tag set with the cut flag on top; status codes 1 and 3 carry no tag here.
   function [15:0] exp_tags(input [1:0] m, input [12:0] p);
      reg [14:0] t;
      integer    k, n;
      begin
         t = {6'h00, m != 2'h2 && !p[4] && !p[3], m != 2'h0 && p[10:8] == 3'h0,
            m != 2'h0 && !p[5], m != 2'h0 && !p[6], m == 2'h2 && !p[7],
            m != 2'h0 && p[10:8] == 3'h4, p[11], !p[12], p[12]};
         if (m == 2'h2) begin
            case (p[2:0])
               3'h0: t[9] = 1'b1;
               3'h2: t[10] = 1'b1;
               3'h4: t[11] = 1'b1;
               3'h5: t[12] = 1'b1;
               3'h6: t[13] = 1'b1;
               3'h7: t[14] = 1'b1;
               default: t[9] = 1'b0;
            endcase
         end
         n = 0;
         for (k = 0; k < 15; k = k + 1) n = n + t[k];
         exp_tags = {n > 6, t};
      end
   endfunction
   task send(input [1:0] m, input [12:0] p, input tg, input [15:0] line);
      integer w;
      begin
         @(posedge clk);
         go <= 1'b1;
         pat <= p;
         trig <= tg;
         @(posedge clk);
         go <= 1'b0;
         trig <= 1'b0;
         w = 0;
         while (sv !== 1'b1 && w < 8) begin
            @(posedge clk);
            #1;
            w = w + 1;
         end
         if (w == 8) begin
            miscompares = miscompares + 1;
            give_verdict;
         end
         chk(exp_tags(m, p), {cut, tags});
         chk(line, sline);
         chk({14'h0, m}, {14'h0, smode});
         chk({3'h0, p}, sa[15:0]);
         chk(16'hffff, sa[15:0] ^ sd[15:0]);
      end
   endtask
   task configure(input [1:0] m, input [1:0] s, input d);
      begin
         @(posedge clk);
         cfg_wr <= 1'b1;
         cfg_mode <= m;
         cfg_sel <= s;
         cfg_drv <= d;
         @(posedge clk);
         cfg_wr <= 1'b0;
         #1 chk(16'h1, {15'h0, brk});
         @(posedge clk);
         #1 chk(16'h0, {14'h0, brk, intr});
         restart <= 1'b1;
         @(posedge clk);
         restart <= 1'b0;
      end
   endtask
   task wait_mode(input [1:0] m);
      integer w;
      begin
         w = 0;
         while (amode !== m && w < 8) begin
            @(posedge clk);
            #1;
            w = w + 1;
         end
         chk({14'h0, m}, {14'h0, amode});
      end
   endtask
   initial begin
      {nrst, go, trig, cfg_wr, restart, cfg_drv, xin, cfg_mode, cfg_sel, pat} = 0;
      miscompares = 0;
      checks = 0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      #1 chk(16'h0005, {sv, tfound, xline, brk, intr, 7'h0, amode, smode});
      for (i = 0; i < 3; i = i + 1) begin
         configure(i[1:0], 2'h0, 1'b0);
         for (j = 0; j < 8; j = j + 1)
            send(i[1:0], {j[0], j[1], j[2:0], j[0], j[1], j[2], j[1], j[2],
               j[2:0]}, 1'b0, ~j[15:0]);
      end
      configure(2'h1, 2'h0, 1'b1);
      send(2'h1, 13'h0a07, 1'b0, 16'hffff);
      send(2'h1, 13'h0a07, 1'b1, 16'h0000);
      #1 chk(16'h7, {13'h0, tfound, xline, intr});
      send(2'h1, 13'h0a07, 1'b1, 16'h0001);
      send(2'h1, 13'h1807, 1'b0, 16'h0002);
      configure(2'h2, 2'h1, 1'b0);
      send(2'h2, 13'h0a07, 1'b1, 16'h0000);
      chk(16'h2, {14'h0, tfound, xline});
      configure(2'h3, 2'h1, 1'b1);
      chk(16'h1, {14'h0, amode});
      send(2'h1, 13'h1c06, 1'b0, 16'hffff);
      send(2'h1, 13'h1c06, 1'b1, 16'h0000);
      wait_mode(2'h2);
      send(2'h2, 13'h1c07, 1'b0, 16'h0001);
      configure(2'h3, 2'h0, 1'b1);
      send(2'h1, 13'h1c06, 1'b1, 16'h0000);
      xin <= 1'b1;
      repeat (8) @(posedge clk);
      xin <= 1'b0;
      #1;
      chk(16'h1, {14'h0, amode});
      give_verdict;
   end
endmodule
